/* rtl/eeprom_pkg.sv */
/*
 * constants, types and state layout for the two-wire eeprom slave write path.
 * assumes a 40 MHz core clock and a bus master that drives the serial clock.
 */
package eeprom_pkg;
    localparam logic [3:0] DEVICE_TYPE_CODE = 4'h5; // arbitrary identity value
    localparam int ADDR_WIDTH = 9;
    localparam int MULTI_LIMIT = 4;
    localparam int PAGE_LIMIT = 8;
    localparam int ROW_BITS = 3;
    localparam int CORE_CLK_MHZ = 40;
    localparam int PROGRAMMING_TIME_LIMIT_MS = 10;
    localparam int PROG_CYCLES = PROGRAMMING_TIME_LIMIT_MS * 1000 * CORE_CLK_MHZ;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    typedef enum logic [2:0] {
        IDLE, DEV_ADDR, WORD_ADDR, DATA, IGNORE, PROGRAM
    } phase_type;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [7:0]            data;
    } write_word_type;

    typedef struct packed {
        logic [1:0]   sclSync;
        logic [1:0]   sdaSync;
        logic         sclPrev;
        logic         sdaPrev;
        phase_type    phase;
        logic [3:0]   bitCount;
        logic [7:0]   shifter;
        logic         ackPhase;
        logic         ackOk;
        logic [ADDR_WIDTH-1:0] addrCounter;
        logic [ADDR_WIDTH-1:0] rowStart;
        logic [3:0]   byteCount;
        logic         crossRow;
        logic [31:0]  progTimer;
        logic         sdaOe;
        logic         busy;
        logic         pageMode;
        logic [1:0]   bufCount;
        write_word_type [1:0] buffer;
        logic         memValid;
        write_word_type memWord;
    } state_type;
endpackage

/* rtl/eeprom_write_slave.sv */
/*
 * two-wire serial slave, write path: address decode, acknowledge,
 * byte/multibyte/page write and a self-timed programming window.
 * assumes pins are asynchronous to core_clk; memory drains memValid/memReady.
 */
`timescale 1ns/1ps
module eeprom_write_slave #(
    parameter int PROG_CYCLES_P = eeprom_pkg::PROG_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   sclIn,
    input  wire logic                   sdaIn,
    output logic                        sdaOut,
    output logic                        sdaOe,
    input  wire logic                   chip_select_strap_low,
    input  wire logic                   chip_select_strap_high,
    input  wire logic                   writeSizeSelect,
    output logic                        busy,
    output logic                        memValid,
    input  wire logic                   memReady,
    output eeprom_pkg::write_word_type  memWord,
    output logic [eeprom_pkg::ADDR_WIDTH-1:0] addrCounter
);
    import eeprom_pkg::*;

    state_type st;
    state_type next_st;
    logic      scl;
    logic      sda;
    logic      sclRise;
    logic      sclFall;
    logic      startSeen;
    logic      stopSeen;
    logic      bufPop;
    logic      bufFull;
    logic [7:0] byteIn;
    logic [ADDR_WIDTH-1:0] nextAddr;
    logic [3:0] limit;

    always_comb begin
        scl       = st.sclSync[1];
        sda       = st.sdaSync[1];
        sclRise   = scl && !st.sclPrev;
        sclFall   = !scl && st.sclPrev;
        startSeen = scl && st.sclPrev && st.sdaPrev && !sda;
        stopSeen  = scl && st.sclPrev && !st.sdaPrev && sda;
        byteIn    = {st.shifter[6:0], sda};
        bufPop    = st.memValid && memReady;
        bufFull   = st.bufCount == 2'd2;
        limit     = st.pageMode ? 4'(PAGE_LIMIT) : 4'(MULTI_LIMIT);
        if (st.pageMode) begin
            nextAddr = {st.addrCounter[ADDR_WIDTH-1:ROW_BITS],
                        st.addrCounter[ROW_BITS-1:0] + 3'd1};
        end else begin
            nextAddr = st.addrCounter + 9'd1;
        end
    end

    always_comb begin
        next_st         = st;
        next_st.sclSync = {st.sclSync[0], sclIn};
        next_st.sdaSync = {st.sdaSync[0], sdaIn};
        next_st.sclPrev = scl;
        next_st.sdaPrev = sda;

        // drain side of the two-entry buffer
        if (bufPop) begin
            next_st.memValid = 1'b0;
        end
        if (!next_st.memValid && st.bufCount != 2'd0) begin
            next_st.memValid = 1'b1;
            next_st.memWord  = st.buffer[0];
            next_st.buffer[0] = st.buffer[1];
            next_st.bufCount = st.bufCount - 2'd1;
        end

        if (st.phase == PROGRAM) begin
            next_st.sdaOe = 1'b0;
            if (st.progTimer != 32'h0000_0000) begin
                next_st.progTimer = st.progTimer - 32'h0000_0001;
            end else if (st.bufCount == 2'd0 && !st.memValid) begin
                next_st.phase = IDLE;
                next_st.busy  = 1'b0;
            end
        end else if (startSeen) begin
            next_st.phase    = DEV_ADDR;
            next_st.bitCount = 4'h0;
            next_st.ackPhase = 1'b0;
            next_st.sdaOe    = 1'b0;
        end else if (stopSeen) begin
            next_st.sdaOe = 1'b0;
            if (st.phase == DATA && st.byteCount != 4'h0) begin
                next_st.phase     = PROGRAM;
                next_st.busy      = 1'b1;
                next_st.progTimer = st.crossRow ? 32'(2 * PROG_CYCLES_P)
                                                : 32'(PROG_CYCLES_P);
            end else begin
                next_st.phase = IDLE;
            end
        end else if (st.phase == DEV_ADDR || st.phase == WORD_ADDR || st.phase == DATA) begin
            if (sclRise && !st.ackPhase) begin
                next_st.shifter  = byteIn;
                next_st.bitCount = st.bitCount + 4'h1;
                if (st.bitCount == BIT_LAST) begin
                    next_st.ackPhase = 1'b1;
                    next_st.ackOk    = 1'b1;
                    case (st.phase)
                        DEV_ADDR: begin
                            if (byteIn[7:4] != DEVICE_TYPE_CODE ||
                                byteIn[3] != chip_select_strap_high ||
                                byteIn[2] != chip_select_strap_low || byteIn[0]) begin
                                next_st.ackOk = 1'b0;
                            end else begin
                                // a foreign address must leave the counter alone
                                next_st.addrCounter[ADDR_WIDTH-1] = byteIn[1];
                                next_st.pageMode = !writeSizeSelect;
                            end
                        end
                        WORD_ADDR: begin
                            next_st.addrCounter[7:0] = byteIn;
                            next_st.rowStart  = {st.addrCounter[ADDR_WIDTH-1], byteIn};
                            next_st.byteCount = 4'h0;
                            next_st.crossRow  = 1'b0;
                        end
                        DATA: begin
                            if (st.byteCount >= limit && !st.pageMode) begin
                                next_st.ackOk = 1'b0;
                            end else if (bufFull) begin
                                next_st.ackOk = 1'b0;
                            end else begin
                                // index after any same-cycle pop
                                next_st.buffer[next_st.bufCount[0]] = '{addr: st.addrCounter,
                                                                        data: byteIn};
                                next_st.bufCount  = next_st.bufCount + 2'd1;
                                next_st.byteCount = (st.byteCount == limit) ? limit
                                                                            : st.byteCount + 4'h1;
                                next_st.addrCounter = nextAddr;
                                if (nextAddr[ADDR_WIDTH-1:ROW_BITS]
                                    != st.rowStart[ADDR_WIDTH-1:ROW_BITS]) begin
                                    next_st.crossRow = !st.pageMode;
                                end
                            end
                        end
                        default: next_st.ackOk = 1'b0;
                    endcase
                end
            end else if (sclFall && st.ackPhase && st.bitCount == BIT_ACK && !st.sdaOe) begin
                next_st.sdaOe = st.ackOk;
                // refused data byte keeps the accepted ones for the stop
                if (!st.ackOk && st.phase != DATA) begin
                    next_st.phase = IGNORE;
                end
                next_st.bitCount = 4'h9;
            end else if (sclFall && st.ackPhase && st.sdaOe) begin
                next_st.sdaOe    = 1'b0;
                next_st.ackPhase = 1'b0;
                next_st.bitCount = 4'h0;
                next_st.phase    = (st.phase == DEV_ADDR) ? WORD_ADDR : DATA;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= '0;
            st.sclSync <= 2'b11;
            st.sdaSync <= 2'b11;
            st.sclPrev <= 1'b1;
            st.sdaPrev <= 1'b1;
            st.phase   <= IDLE;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdaOut      <= 1'b0;
            sdaOe       <= 1'b0;
            busy        <= 1'b0;
            memValid    <= 1'b0;
            memWord     <= '0;
            addrCounter <= '0;
        end else begin
            sdaOut      <= 1'b0;
            sdaOe       <= next_st.sdaOe;
            busy        <= next_st.busy;
            memValid    <= next_st.memValid;
            memWord     <= next_st.memWord;
            addrCounter <= next_st.addrCounter;
        end
    end
endmodule

/* verif/eeprom_write_props.sv */
/* checker for the eeprom write slave ports.
   assumes bind into every eeprom_write_slave instance. */
`timescale 1ns/1ps
module eeprom_write_props #(
    parameter int PROG_CYCLES_P = 200
) (
    input wire logic                       core_clk,
    input wire logic                       rst_n,
    input wire logic                       sclIn,
    input wire logic                       sdaIn,
    input wire logic                       sdaOut,
    input wire logic                       sdaOe,
    input wire logic                       busy,
    input wire logic                       memValid,
    input wire logic                       memReady,
    input wire eeprom_pkg::write_word_type memWord
);
    import eeprom_pkg::*;
    localparam int LIM = 2 * PROG_CYCLES_P + 64;
    int cnt;
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) cnt <= 0;
        else cnt <= busy ? cnt + 1 : 0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ackRise; $rose(sdaOe); endsequence
    property p_odrain; sdaOut == 1'b0; endproperty
    property p_quiet; busy |-> !sdaOe; endproperty
    property p_hold; memValid && !memReady |=> memValid && $stable(memWord); endproperty
    property p_acklow; s_ackRise |-> !sclIn; endproperty
    property p_ackhold; sdaOe && sclIn |=> sdaOe; endproperty
    property p_ackw; s_ackRise |-> sdaOe [*4]; endproperty
    property p_stop; $rose(busy) |-> sclIn && sdaIn; endproperty
    property p_prog; $fell(busy) |-> cnt >= PROG_CYCLES_P && cnt <= LIM; endproperty
    a_odrain: assert property (p_odrain) else $error("sda driven high");
    a_quiet: assert property (p_quiet) else $error("ack while busy");
    a_hold: assert property (p_hold) else $error("word lost in stall");
    a_acklow: assert property (p_acklow) else $error("ack with clock high");
    a_ackhold: assert property (p_ackhold) else $error("ack dropped early");
    a_ackw: assert property (p_ackw) else $error("ack too short");
    a_stop: assert property (p_stop) else $error("busy without stop");
    a_prog: assert property (p_prog) else $error("program time off");
endmodule
bind eeprom_write_slave eeprom_write_props #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_props (
    .core_clk(core_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .busy(busy), .memValid(memValid),
    .memReady(memReady), .memWord(memWord));

/* verif/i2c_master_model.sv */
/* two-wire bus master model, 200 ns bit clock.
   assumes slave pulls sda low through slaveOe; sda has a pull-up. */
`timescale 1ns/1ps
module i2c_master_model (
    output logic      scl,
    output wire logic sda,
    input  wire logic slaveOe
);
    logic sdaLow = 1'b0;
    initial scl = 1'b1;
    assign sda = !(sdaLow || slaveOe);
    task automatic start;
        #25 sdaLow = 1'b0;
        #75 scl = 1'b1;
        #100 sdaLow = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic stop;
        #25 sdaLow = 1'b1;
        #75 scl = 1'b1;
        #100 sdaLow = 1'b0;
        #100;
    endtask
    task automatic xfer(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #25 sdaLow = !b[i];
            #75 scl = 1'b1;
            #100 scl = 1'b0;
        end
        #25 sdaLow = 1'b0;
        #75 scl = 1'b1;
        #75 ack = !sda;
        #25 scl = 1'b0;
    endtask
endmodule

/* verif/testbench.sv */
/* write-path tests: byte, multibyte, page, refusals, busy.
   assumes eeprom_pkg and the bus master model. */
`timescale 1ns/1ps
module testbench;
    import eeprom_pkg::*;
    logic           core_clk = 0, rst_n = 0, memReady = 0, wss = 1;
    logic           sdaOut, sdaOe, busy, memValid, scl, sda;
    write_word_type memWord, q[$];
    logic [8:0]     addrCounter;
    logic [15:0]    ackv;
    logic [7:0]     bad[3] = '{{~DEVICE_TYPE_CODE, 4'h8}, {DEVICE_TYPE_CODE, 4'h4},
                               {DEVICE_TYPE_CODE, 4'h9}};
    int             miscompares = 0, num_checks = 0, cyc = 0;
    eeprom_write_slave #(.PROG_CYCLES_P(200)) dut (.core_clk(core_clk), .rst_n(rst_n),
        .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .chip_select_strap_low(1'b0), .chip_select_strap_high(1'b1),
        .writeSizeSelect(wss), .busy(busy), .memValid(memValid),
        .memReady(memReady), .memWord(memWord), .addrCounter(addrCounter));
    i2c_master_model bm (.scl(scl), .sda(sda), .slaveOe(sdaOe));
    initial forever #12.5 core_clk = ~core_clk;
    // stalls of 32 cycles on the memory side
    always @(posedge core_clk) begin
        cyc++;
        if (memValid === 1'b1 && memReady === 1'b1) q.push_back(memWord);
        #2 memReady = !cyc[5];
    end
    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] sa, wa, d0, input int n);
        logic a;
        ackv = 0;
        bm.start();
        bm.xfer(sa, a);
        ackv[0] = a;
        bm.xfer(wa, a);
        ackv[1] = a;
        for (int i = 0; i < n; i++) begin
            bm.xfer(8'(d0 + i), a);
            ackv[i+2] = a;
        end
        bm.stop();
    endtask
    task automatic idle;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge core_clk);
        chk("busy", 0, 17'(busy));
    endtask
    task automatic words(input logic [8:0] a0, input logic [7:0] d0, input int n, pg);
        logic [8:0] a;
        chk("count", 17'(n), 17'(q.size()));
        for (int i = 0; i < n && q.size() > 0; i++) begin
            a = pg ? {a0[8:3], 3'(a0[2:0] + i)} : 9'(a0 + i);
            chk("word", {a, 8'(d0 + i)}, q.pop_front());
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400_000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        #2 rst_n = 1;
        #200;
        wr({DEVICE_TYPE_CODE, 4'hA}, 8'h3E, 8'hA5, 1);
        chk("ack", 17'h7, 17'(ackv));
        chk("busy", 1, 17'(busy));
        wr({DEVICE_TYPE_CODE, 4'h8}, 8'h00, 8'h11, 1);
        chk("ack", 0, 17'(ackv));
        idle();
        words(9'h13E, 8'hA5, 1, 0);
        chk("next", 17'h13F, 17'(addrCounter));
        foreach (bad[i]) begin
            wr(bad[i], 8'h00, 8'h22, 2);
            chk("ack", 0, 17'(ackv));
            chk("count", 0, 17'(q.size()));
        end
        wr({DEVICE_TYPE_CODE, 4'h8}, 8'h06, 8'h30, 5);
        chk("ack", 17'h3F, 17'(ackv));
        chk("busy", 1, 17'(busy));
        idle();
        words(9'h006, 8'h30, 4, 0);
        @(posedge core_clk) #2 wss = 0;
        wr({DEVICE_TYPE_CODE, 4'h8}, 8'h1D, 8'h40, 9);
        chk("ack", 17'h7FF, 17'(ackv));
        idle();
        words(9'h01D, 8'h40, 9, 1);
        chk("next", 17'h01E, 17'(addrCounter));
        stop_test();
    end
endmodule
